// *** rtl/pmsc_engine.sv ***
// Statistics engine with independent and linked collection modes
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module pmsc_engine import pmsc_pkg::*; #(
	parameter int N  = OBS_COUNT_DEF,
	parameter int W  = VAL_WIDTH_DEF,
	parameter int SH = AVG_SHIFT_DEF
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               restart,
	// Observable samples
	input  wire logic               sample_valid,
	input  wire logic [N*16-1:0]    sample,
	// Command channel
	input  wire pmsc_cmd_s          cmd,
	output var  logic               rsp_valid,
	output var  logic [15:0]        rsp_feature,
	output var  pmsc_stat_s [N-1:0] rsp_stats,
	output var  logic               rsp_alarm,
	// Monitor page path
	input  wire logic               mon_wr,
	input  wire logic [7:0]         mon_page,
	output var  pmsc_stat_s [N-1:0] mon_stats,
	output var  logic               mode
);

	//------------------------------------------------------------
	// Statistics update
	//------------------------------------------------------------
	function automatic pmsc_stat_s upd(input pmsc_stat_s s, input logic [15:0] v, input logic fresh);
		pmsc_stat_s r;
		r = s;
		r.cur = v;
		if (fresh) begin
			r.min = v;
			r.max = v;
			r.avg = v;
		end else begin
			if (v < s.min) r.min = v;
			if (v > s.max) r.max = v;
			// Exponential average; trades accuracy for no divider
			r.avg = 16'(s.avg - (s.avg >> SH) + (v >> SH));
		end
		return r;
	endfunction

	pmsc_stat_s [N-1:0] set_c, set_m, next_set_c, next_set_m;
	logic [N-1:0]       empty_c, empty_m, next_empty_c, next_empty_m;
	logic               next_mode;
	logic               next_rsp_valid;
	logic [15:0]        next_rsp_feature;
	pmsc_stat_s [N-1:0] next_rsp_stats, next_mon_stats;
	logic               clr_cmd, clr_mon, mode_chg;

	assign clr_cmd  = cmd.valid && cmd.opcode == CMD_CLEAR;
	assign clr_mon  = mon_wr && mon_page == MON_CLEAR_PAGE;
	assign mode_chg = cmd.valid && cmd.opcode == CMD_MODE_SET && cmd.arg[0] != mode;

	always_comb begin
		next_mode = mode;
		if (cmd.valid && cmd.opcode == CMD_MODE_SET)
			next_mode = cmd.arg[0];
		if (restart)
			next_mode = PMSC_INDEP;
	end

	always_comb begin
		logic clear_c;
		logic clear_m;
		logic all_clr;
		all_clr = mode_chg || (restart && mode != PMSC_INDEP);
		clear_c = all_clr || clr_cmd || (mode == PMSC_LINKED && clr_mon);
		clear_m = all_clr || clr_mon || (mode == PMSC_LINKED && clr_cmd);
		next_set_c = set_c;
		next_set_m = set_m;
		next_empty_c = empty_c;
		next_empty_m = empty_m;
		for (int i = 0; i < N; i++) begin
			if (sample_valid) begin
				next_set_c[i] = upd(set_c[i], sample[i*16 +: 16], empty_c[i]);
				next_set_m[i] = upd(set_m[i], sample[i*16 +: 16], empty_m[i]);
				next_empty_c[i] = 1'b0;
				next_empty_m[i] = 1'b0;
			end
			// A clear restarts the interval; the sample in that cycle is dropped
			if (clear_c) next_empty_c[i] = 1'b1;
			if (clear_m) next_empty_m[i] = 1'b1;
			if (clear_c) next_set_c[i] = '0;
			if (clear_m) next_set_m[i] = '0;
			if (mode == PMSC_LINKED && !all_clr) next_set_m[i] = next_set_c[i];
			if (mode == PMSC_LINKED && !all_clr) next_empty_m[i] = next_empty_c[i];
		end
	end

	always_comb begin
		next_rsp_valid = 1'b0;
		next_rsp_feature = rsp_feature;
		next_rsp_stats = rsp_stats;
		next_mon_stats = set_m;
		if (cmd.valid) begin
			next_rsp_valid = 1'b1;
			if (cmd.opcode == CMD_FEATURE_A || cmd.opcode == CMD_FEATURE_B)
				next_rsp_feature = FEATURE_MAP;
			if (cmd.opcode == CMD_READ)
				next_rsp_stats = set_c;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mode        <= MODE_RST_VAL;
			set_c       <= '0;
			set_m       <= '0;
			empty_c     <= '1;
			empty_m     <= '1;
			rsp_valid   <= 1'b0;
			rsp_feature <= '0;
			rsp_stats   <= '0;
			mon_stats   <= '0;
			rsp_alarm   <= 1'b0;
		end else begin
			mode        <= next_mode;
			set_c       <= next_set_c;
			set_m       <= next_set_m;
			empty_c     <= next_empty_c;
			empty_m     <= next_empty_m;
			rsp_valid   <= next_rsp_valid;
			rsp_feature <= next_rsp_feature;
			rsp_stats   <= next_rsp_stats;
			mon_stats   <= next_mon_stats;
			rsp_alarm   <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Check sequences
	//------------------------------------------------------------
	// Single-cycle command and sample conditions, shared by the checks below
	sequence s_any_cmd;
		cmd.valid;
	endsequence

	sequence s_mode_cmd;
		cmd.valid && cmd.opcode == CMD_MODE_SET && !restart;
	endsequence

	sequence s_read_cmd;
		cmd.valid && cmd.opcode == CMD_READ;
	endsequence

	sequence s_feature_cmd;
		cmd.valid && (cmd.opcode == CMD_FEATURE_A || cmd.opcode == CMD_FEATURE_B);
	endsequence

	sequence s_plain_sample;
		sample_valid && !clr_cmd && !clr_mon && !mode_chg && !restart;
	endsequence

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	// Mode control
	chk_reset_indep: assert property (
		@(posedge clock)
		rst |=> mode == PMSC_INDEP
	) else $error("mode not independent after reset");

	chk_restart_indep: assert property (
		@(posedge clock) disable iff (rst)
		restart |=> mode == PMSC_INDEP
	) else $error("restart kept linked");

	chk_mode_set: assert property (
		@(posedge clock) disable iff (rst)
		s_mode_cmd |=> mode == $past(cmd.arg[0])
	) else $error("mode set ignored");

	chk_mode_hold: assert property (
		@(posedge clock) disable iff (rst)
		(!cmd.valid && !restart) |=> $stable(mode)
	) else $error("mode moved without a command");

	// Clearing on mode change and restart
	chk_change_clear: assert property (
		@(posedge clock) disable iff (rst)
		(mode_chg && !restart) |=> (&empty_c) && (&empty_m)
	) else $error("mode change did not clear");

	chk_restart_clear: assert property (
		@(posedge clock) disable iff (rst)
		(restart && mode == PMSC_LINKED) |=> (&empty_c) && (&empty_m)
	) else $error("restart from linked did not clear");

	// Independent sets
	chk_indep_sep: assert property (
		@(posedge clock) disable iff (rst)
		(mode == PMSC_INDEP && clr_mon && !clr_cmd && !mode_chg && !restart && !sample_valid)
		|=> set_c == $past(set_c)
	) else $error("monitor clear hit command set");

	chk_indep_keep_m: assert property (
		@(posedge clock) disable iff (rst)
		(mode == PMSC_INDEP && clr_cmd && !clr_mon && !mode_chg && !restart && !sample_valid)
		|=> set_m == $past(set_m)
	) else $error("command clear hit monitor set");

	chk_cmd_clr: assert property (
		@(posedge clock) disable iff (rst)
		clr_cmd |=> &empty_c
	) else $error("command clear missed");

	chk_mon_clr: assert property (
		@(posedge clock) disable iff (rst)
		clr_mon |=> &empty_m
	) else $error("monitor clear missed");

	// Linked set
	chk_linked_same: assert property (
		@(posedge clock) disable iff (rst)
		(mode == PMSC_LINKED && $past(mode) == PMSC_LINKED && !$past(rst)) |-> set_c == set_m
	) else $error("linked sets differ");

	chk_linked_clr: assert property (
		@(posedge clock) disable iff (rst)
		(mode == PMSC_LINKED && (clr_cmd || clr_mon)) |=> (&empty_c) && (&empty_m)
	) else $error("linked clear missed");

	// Statistics values
	chk_cur_track: assert property (
		@(posedge clock) disable iff (rst)
		s_plain_sample |=> set_c[0].cur == $past(sample[15:0])
	) else $error("current value not taken");

	chk_min_order: assert property (
		@(posedge clock) disable iff (rst)
		!empty_c[0] |-> set_c[0].min <= set_c[0].max
	) else $error("minimum above maximum");

	// Both paths run together; the monitor copy trails by one cycle
	chk_mon_follow: assert property (
		@(posedge clock) disable iff (rst)
		1'b1 |=> mon_stats == $past(set_m)
	) else $error("monitor copy stale");

	// Command answers
	chk_rsp_pulse: assert property (
		@(posedge clock) disable iff (rst)
		s_any_cmd |=> rsp_valid
	) else $error("no answer to a command");

	chk_rsp_idle: assert property (
		@(posedge clock) disable iff (rst)
		!cmd.valid |=> !rsp_valid
	) else $error("answer without a command");

	chk_read_snap: assert property (
		@(posedge clock) disable iff (rst)
		s_read_cmd |=> rsp_stats == $past(set_c)
	) else $error("read snapshot wrong");

	chk_no_alarm: assert property (
		@(posedge clock) disable iff (rst)
		##1 !rsp_alarm
	) else $error("alarm on polled path");

	chk_feature_ans: assert property (
		@(posedge clock) disable iff (rst)
		s_feature_cmd |=> rsp_valid && rsp_feature == FEATURE_MAP
	) else $error("feature answer wrong");

endmodule
`default_nettype wire

// *** rtl/pmsc_pkg.sv ***
// Shared constants and carrier types for the statistics mode engine
package pmsc_pkg;

	localparam int OBS_COUNT_DEF = 4;
	localparam int VAL_WIDTH_DEF = 16;
	localparam int AVG_SHIFT_DEF = 3;
	localparam logic [15:0] CMD_FEATURE_A = 16'h0042;
	localparam logic [15:0] CMD_FEATURE_B = 16'h0201;
	localparam logic [15:0] CMD_MODE_SET  = 16'h0200;
	localparam logic [15:0] CMD_CLEAR     = 16'h0202;
	localparam logic [15:0] CMD_READ      = 16'h0203;
	localparam logic [15:0] FEATURE_MAP   = 16'h0007;
	localparam logic [7:0]  MON_CLEAR_PAGE = 8'h2F;
	localparam logic        MODE_RST_VAL  = 1'b0;

	typedef enum logic {
		PMSC_INDEP  = 1'b0,
		PMSC_LINKED = 1'b1
	} pmsc_mode_e;

	typedef struct packed {
		logic        valid;
		logic [15:0] opcode;
		logic [7:0]  arg;
	} pmsc_cmd_s;

	typedef struct packed {
		logic [15:0] min;
		logic [15:0] avg;
		logic [15:0] max;
		logic [15:0] cur;
	} pmsc_stat_s;

endpackage

// *** verification/pmsc_host.sv ***
// Host controller model that polls the statistics command channel
`timescale 1ns/10ps
`default_nettype none
module pmsc_host import pmsc_pkg::*; (
	// Clock
	input  wire logic     clock,
	// Command channel
	output var pmsc_cmd_s cmd,
	input  wire logic     rsp_valid
);
	logic seen;
	initial cmd = '0;
	// One command per exchange, answer sampled in the following cycle
	task send(input logic [15:0] op, input logic [7:0] arg);
		@(negedge clock);
		cmd = '{1'b1, op, arg};
		@(negedge clock);
		cmd = '{1'b0, ~op, ~arg};
		seen = rsp_valid;
	endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the statistics mode engine
`timescale 1ns/10ps
`default_nettype none
module tb import pmsc_pkg::*;;
	logic              clock = 0, rst = 1, restart = 0, sample_valid = 0, mon_wr = 0;
	logic [63:0]       sample = '0;
	logic [7:0]        mon_page = '0;
	pmsc_cmd_s         cmd;
	logic              rsp_valid, rsp_alarm, mode;
	logic [15:0]       rsp_feature, a, b;
	pmsc_stat_s [3:0]  rsp_stats, mon_stats;
	int                failures = 0, n_checks = 0;
	always #5 clock = ~clock;
	pmsc_host host (.clock(clock), .cmd(cmd), .rsp_valid(rsp_valid));
	pmsc_engine #(.N(4)) dut (.clock(clock), .rst(rst), .restart(restart), .sample_valid(sample_valid),
		.sample(sample), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_feature(rsp_feature), .rsp_stats(rsp_stats),
		.rsp_alarm(rsp_alarm), .mon_wr(mon_wr), .mon_page(mon_page), .mon_stats(mon_stats), .mode(mode));
	task close_out;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Observable i sees v xor i, so every lane carries its own value
	task put(input logic [15:0] v);
		@(negedge clock);
		for (int i = 0; i < 4; i++) sample[i*16+:16] = v ^ 16'(i);
		sample_valid = 1;
		@(negedge clock);
		sample_valid = 0;
		sample = ~sample;
	endtask
	task mon(input logic [7:0] pg);
		@(negedge clock);
		mon_wr = 1;
		mon_page = pg;
		@(negedge clock);
		mon_wr = 0;
		mon_page = ~pg;
		@(negedge clock);
	endtask
	// Average is only predictable after a single sample
	task stats(input string nm, input pmsc_stat_s [3:0] s, input logic [15:0] x, y, input bit clr);
		logic [15:0] p, q;
		for (int i = 0; i < 4; i++) begin
			p = x ^ 16'(i);
			q = y ^ 16'(i);
			chk(nm, clr ? 16'h0000 : (p < q ? p : q), s[i].min);
			chk(nm, clr ? 16'h0000 : (p < q ? q : p), s[i].max);
			if (!clr) chk(nm, q, s[i].cur);
			if (!clr && p == q) chk(nm, p, s[i].avg);
		end
	endtask
	initial begin
		#100000;
		failures++;
		close_out();
	end
	initial begin
		a = 16'($urandom(75392));
		b = 16'($urandom);
		repeat (3) @(negedge clock);
		rst = 0;
		chk("mode", 16'h0000, {15'h0000, mode});
		host.send(CMD_READ, 8'h00);
		host.send(CMD_FEATURE_A, 8'($urandom));
		chk("feature", FEATURE_MAP, rsp_feature);
		host.send(CMD_FEATURE_B, 8'($urandom));
		chk("feature", FEATURE_MAP, rsp_feature);
		chk("rsp_valid", 16'h0001, {15'h0000, host.seen});
		$display("test feature done");
		put(a);
		put(b);
		host.send(CMD_READ, 8'h00);
		stats("cmd", rsp_stats, a, b, 0);
		stats("mon", mon_stats, a, b, 0);
		chk("alarm", 16'h0000, {15'h0000, rsp_alarm});
		mon(MON_CLEAR_PAGE);
		stats("mon", mon_stats, a, a, 1);
		host.send(CMD_READ, 8'h00);
		stats("cmd", rsp_stats, a, b, 0);
		$display("test independent done");
		host.send(CMD_MODE_SET, 8'h01);
		chk("mode", 16'h0001, {15'h0000, mode});
		host.send(CMD_READ, 8'h00);
		stats("cmd", rsp_stats, a, a, 1);
		stats("mon", mon_stats, a, a, 1);
		put(b);
		host.send(CMD_READ, 8'h00);
		stats("cmd", rsp_stats, b, b, 0);
		stats("mon", mon_stats, b, b, 0);
		mon(MON_CLEAR_PAGE);
		host.send(CMD_READ, 8'h00);
		stats("cmd", rsp_stats, a, a, 1);
		$display("test linked done");
		@(negedge clock);
		restart = 1;
		@(negedge clock);
		restart = 0;
		chk("mode", 16'h0000, {15'h0000, mode});
		$display("test restart done");
		close_out();
	end
endmodule
`default_nettype wire
